/* rtl/tsp_pkg.sv */
// constants and types for the temperature sensor serial slave port
`default_nettype none
package tsp_pkg;
    localparam logic [4:0] ADDR_UPPER = 5'h12;
    localparam logic [7:0] GCALL_BYTE = 8'h00;
    localparam logic [7:0] GCALL_RESET = 8'h06;
    localparam logic [7:0] PTR_RESET_CMD = 8'h2F;
    localparam logic [7:0] PTR_DEFAULT = 8'h00;
    localparam logic [7:0] PTR_TEMP_MSB = 8'h00;
    localparam logic [7:0] PTR_HIGH_MSB = 8'h04;
    localparam logic [7:0] PTR_LOW_MSB = 8'h06;
    localparam logic [7:0] PTR_CRIT_MSB = 8'h08;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [1:0] IDX_MAX = 2'h3;
    localparam int RELOAD_TIME_US = 200;
    localparam int CORE_CLK_MHZ = 25;
    localparam int RELOAD_CYCLES_DEF = RELOAD_TIME_US * CORE_CLK_MHZ;
    localparam int BUSY_CNT_W = 16;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_WAIT
    } tsp_state_t;
endpackage
`default_nettype wire

/* rtl/tsp_i2c_slave.sv */
// serial slave port: link-side protocol engine and core-side register access
`timescale 1ns/1ns
`default_nettype none
module tsp_i2c_slave #(
    parameter int unsigned RELOAD_CYCLES = tsp_pkg::RELOAD_CYCLES_DEF
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic LINK_CLK_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic ADDR_SELECT_LSB_PIN_I,
    input wire logic ADDR_SELECT_MSB_PIN_I,
    output logic [7:0] REG_ADDR_O,
    output logic [7:0] REG_WDATA_O,
    output logic REG_WR_O,
    output logic REG_RD_O,
    input wire logic [7:0] REG_RDATA_I,
    output logic DEFAULTS_RELOAD_O,
    output logic RELOAD_BUSY_O
);
    import tsp_pkg::*;

    // link domain signals
    logic [1:0] rst_sy, ce_sy, sel_lsb_sy, sel_msb_sy, busy_sy;
    logic rst_l, ce_l, busy_l;
    logic [2:0] scl_sy, sda_sy, ack_sy;
    logic scl_f, sda_f, scl_d, sda_d;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [7:0] rd_data_l, shreg, ptr, xfer_addr, wr_data;
    tsp_state_t state;
    logic [3:0] bit_cnt;
    logic sda_oe, rd_mode, gcall, pend_rst, acked;
    logic [1:0] byte_idx;
    logic tgl_wr, tgl_rd, tgl_rst;
    logic addr_hit, gcall_hit, rw_bit;

    // core domain signals
    logic [2:0] ev_s1, ev_s2, ev_s3, ev;
    logic rd_pend, tgl_ack, busy_reg;
    logic [7:0] rd_hold;
    logic [BUSY_CNT_W-1:0] busy_cnt;

    function automatic logic pair_msb(input logic [7:0] p);
        pair_msb = (p == PTR_TEMP_MSB) || (p == PTR_HIGH_MSB) || (p == PTR_LOW_MSB) || (p == PTR_CRIT_MSB);
    endfunction

    function automatic logic limit_msb(input logic [7:0] p);
        limit_msb = (p == PTR_HIGH_MSB) || (p == PTR_LOW_MSB) || (p == PTR_CRIT_MSB);
    endfunction

    // reset and enable come from the core clock, so they cross like any level
    always_ff @(posedge LINK_CLK_I) begin
        rst_sy <= {rst_sy[0], RST_I};
        ce_sy <= {ce_sy[0], CE_I};
    end
    assign rst_l = rst_sy[1];
    assign ce_l = ce_sy[1];

    // pin synchronisers; third stage of scl and sda only feeds the glitch filter, that of ack_sy the toggle detector
    always_ff @(posedge LINK_CLK_I) begin
        if (ce_l) begin
            scl_sy <= {scl_sy[1:0], SCL_I};
            sda_sy <= {sda_sy[1:0], SDA_I};
            sel_lsb_sy <= {sel_lsb_sy[0], ADDR_SELECT_LSB_PIN_I};
            sel_msb_sy <= {sel_msb_sy[0], ADDR_SELECT_MSB_PIN_I};
            ack_sy <= {ack_sy[1:0], tgl_ack};
            busy_sy <= {busy_sy[0], busy_reg};
        end
    end
    assign busy_l = busy_sy[1];

    // a level is accepted only after two equal samples, so one-sample spikes vanish
    always_ff @(posedge LINK_CLK_I) begin
        if (rst_l) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_l) begin
            if (scl_sy[2] == scl_sy[1]) begin
                scl_f <= scl_sy[1];
            end
            if (sda_sy[2] == sda_sy[1]) begin
                sda_f <= sda_sy[1];
            end
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_ev = scl_f & scl_d & ~sda_d & sda_f;
    assign rw_bit = shreg[0];
    assign addr_hit = ~busy_l && (shreg[7:1] == {ADDR_UPPER, sel_msb_sy[1], sel_lsb_sy[1]});
    assign gcall_hit = ~busy_l && (shreg == GCALL_BYTE);

    // read data arrives with the acknowledge toggle; data is stable by then
    always_ff @(posedge LINK_CLK_I) begin
        if (rst_l) begin
            rd_data_l <= 8'h00;
        end else if (ce_l && (ack_sy[2] ^ ack_sy[1])) begin
            rd_data_l <= rd_hold;
        end
    end

    // protocol engine
    always_ff @(posedge LINK_CLK_I) begin
        if (rst_l) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sda_oe <= 1'b0;
            rd_mode <= 1'b0;
            gcall <= 1'b0;
            byte_idx <= 2'h0;
            ptr <= PTR_DEFAULT;
            pend_rst <= 1'b0;
            acked <= 1'b0;
            xfer_addr <= PTR_DEFAULT;
            wr_data <= 8'h00;
            tgl_wr <= 1'b0;
            tgl_rd <= 1'b0;
            tgl_rst <= 1'b0;
        end else if (ce_l) begin
            if (start_ev) begin
                // a repeated start also ends the old direction
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                pend_rst <= 1'b0;
            end else if (stop_ev) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                if (pend_rst) begin
                    pend_rst <= 1'b0;
                    ptr <= PTR_DEFAULT;
                    tgl_rst <= ~tgl_rst;
                end
            end else begin
                case (state)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                            bit_cnt <= 4'h0;
                            byte_idx <= 2'h0;
                            rd_mode <= rw_bit;
                            gcall <= gcall_hit && !addr_hit;
                            if (addr_hit || gcall_hit) begin
                                state <= ST_ADDR_ACK;
                                sda_oe <= 1'b1;
                                if (rw_bit) begin
                                    xfer_addr <= ptr;
                                    tgl_rd <= ~tgl_rd;
                                end
                            end else begin
                                state <= ST_WAIT;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rd_mode) begin
                                state <= ST_RD_BYTE;
                                shreg <= {rd_data_l[6:0], 1'b0};
                                sda_oe <= ~rd_data_l[7];
                            end else begin
                                state <= ST_WR_BYTE;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WR_BYTE: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                            bit_cnt <= 4'h0;
                            if (gcall) begin
                                if (shreg == GCALL_RESET) begin
                                    state <= ST_WR_ACK;
                                    sda_oe <= 1'b1;
                                    ptr <= PTR_DEFAULT;
                                    tgl_rst <= ~tgl_rst;
                                end else begin
                                    state <= ST_WAIT;
                                end
                            end else begin
                                state <= ST_WR_ACK;
                                sda_oe <= 1'b1;
                                if (byte_idx == 2'h0) begin
                                    ptr <= shreg;
                                    pend_rst <= (shreg == PTR_RESET_CMD);
                                end else if (byte_idx == 2'h1) begin
                                    xfer_addr <= ptr;
                                    wr_data <= shreg;
                                    tgl_wr <= ~tgl_wr;
                                    pend_rst <= 1'b0;
                                end else if (byte_idx == 2'h2 && limit_msb(ptr)) begin
                                    // pointer itself stays on the MSB address
                                    xfer_addr <= ptr + 8'h01;
                                    wr_data <= shreg;
                                    tgl_wr <= ~tgl_wr;
                                end
                                // later bytes are acknowledged but dropped
                            end
                        end
                    end
                    ST_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= gcall ? ST_WAIT : ST_WR_BYTE;
                            if (byte_idx != IDX_MAX) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                    ST_RD_BYTE: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            // step early so the LSB is fetched before the master acks
                            if (bit_cnt == LAST_BIT && byte_idx == 2'h0 && pair_msb(ptr)) begin
                                ptr <= ptr + 8'h01;
                                xfer_addr <= ptr + 8'h01;
                                tgl_rd <= ~tgl_rd;
                            end
                        end else if (scl_fall) begin
                            if (bit_cnt == BYTE_BITS) begin
                                bit_cnt <= 4'h0;
                                sda_oe <= 1'b0;
                                state <= ST_RD_ACK;
                            end else begin
                                sda_oe <= ~shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (scl_rise) begin
                            acked <= ~sda_f;
                        end else if (scl_fall) begin
                            if (acked) begin
                                // no block reads: extra bytes repeat the last fetched register
                                state <= ST_RD_BYTE;
                                shreg <= {rd_data_l[6:0], 1'b0};
                                sda_oe <= ~rd_data_l[7];
                                if (byte_idx != IDX_MAX) begin
                                    byte_idx <= byte_idx + 2'h1;
                                end
                            end else begin
                                state <= ST_WAIT;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;

    // core side: toggle events from the link, detected after two flip-flops
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ev_s1 <= 3'h0;
            ev_s2 <= 3'h0;
            ev_s3 <= 3'h0;
        end else if (CE_I) begin
            ev_s1 <= {tgl_rst, tgl_rd, tgl_wr};
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
        end
    end
    assign ev = ev_s2 ^ ev_s3;

    // register access strobes; address and data held stable by the link until next toggle
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            REG_ADDR_O <= PTR_DEFAULT;
            REG_WDATA_O <= 8'h00;
            REG_WR_O <= 1'b0;
            REG_RD_O <= 1'b0;
            rd_pend <= 1'b0;
            rd_hold <= 8'h00;
            tgl_ack <= 1'b0;
        end else if (CE_I) begin
            REG_WR_O <= ev[0];
            REG_RD_O <= ev[1];
            rd_pend <= ev[1];
            if (ev[0] || ev[1]) begin
                REG_ADDR_O <= xfer_addr;
            end
            if (ev[0]) begin
                REG_WDATA_O <= wr_data;
            end
            if (rd_pend) begin
                rd_hold <= REG_RDATA_I;
                tgl_ack <= ~tgl_ack;
            end
        end
    end

    // default reload: one pulse, with a busy window from the same cycle that blocks acknowledges
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            DEFAULTS_RELOAD_O <= 1'b0;
            busy_reg <= 1'b0;
            busy_cnt <= '0;
        end else if (CE_I) begin
            DEFAULTS_RELOAD_O <= ev[2];
            if (ev[2]) begin
                busy_reg <= 1'b1;
                busy_cnt <= BUSY_CNT_W'(RELOAD_CYCLES);
            end else if (busy_cnt > BUSY_CNT_W'(1)) begin
                busy_cnt <= busy_cnt - BUSY_CNT_W'(1);
            end else begin
                busy_cnt <= '0;
                busy_reg <= 1'b0;
            end
        end
    end
    assign RELOAD_BUSY_O = busy_reg;

    sequence s_addr_end;
        ce_l && state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS;
    endsequence

    sequence s_wr_end;
        ce_l && state == ST_WR_BYTE && scl_fall && bit_cnt == BYTE_BITS;
    endsequence

    addr_ack_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        (s_addr_end ##0 addr_hit) |=> sda_oe && state == ST_ADDR_ACK)
        else $error("matching address not acknowledged");

    addr_nack_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        (s_addr_end ##0 (!addr_hit && !gcall_hit)) |=> !sda_oe && state == ST_WAIT)
        else $error("foreign address not released");

    rw_dir_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        (s_addr_end ##0 addr_hit) |=> rd_mode == $past(rw_bit))
        else $error("direction not taken from address byte");

    sda_change_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        $rose(sda_oe) |-> !scl_f)
        else $error("sda driven while scl high");

    stop_idle_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        ce_l && stop_ev |=> state == ST_IDLE && !sda_oe)
        else $error("stop not honoured");

    ptr_load_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        (s_wr_end ##0 (!gcall && byte_idx == 2'h0)) |=> ptr == $past(shreg))
        else $error("pointer not loaded from first byte");

    auto_inc_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        ce_l && state == ST_RD_BYTE && scl_rise && bit_cnt == LAST_BIT && byte_idx == 2'h0 && pair_msb(ptr)
        |=> ptr == $past(ptr) + 8'h01)
        else $error("pointer did not step to lsb");

    gcall_nack_a: assert property (@(posedge LINK_CLK_I) disable iff (rst_l)
        (s_wr_end ##0 (gcall && shreg != GCALL_RESET)) |=> !sda_oe && state == ST_WAIT)
        else $error("unknown general call acknowledged");

    reload_busy_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        CE_I && ev[2] |=> RELOAD_BUSY_O && DEFAULTS_RELOAD_O && busy_cnt == BUSY_CNT_W'(RELOAD_CYCLES))
        else $error("reload window not started");

    wr_strobe_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        CE_I && ev[0] |=> REG_WR_O && REG_ADDR_O == $past(xfer_addr) && REG_WDATA_O == $past(wr_data))
        else $error("register write strobe missing");

    rd_strobe_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        CE_I && ev[1] |=> REG_RD_O ##1 (!$past(CE_I) || rd_hold == $past(REG_RDATA_I)))
        else $error("register read not issued");
endmodule
`default_nettype wire

/* testbench/tsp_bus_master.sv */
// bus master model driving the serial clock and pulling the data line
`timescale 1ns/1ns
`default_nettype none
module tsp_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // quarter bit of 12 core cycles keeps scl low well over the 300 ns fetch time
    task automatic q();
        repeat (12) @(posedge clk_i);
    endtask
    task automatic start();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask
    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o <= !b;
        q();
        scl_o <= 1'b1;
        q();
        r = sda_i;
        q();
        scl_o <= 1'b0;
        q();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // no acknowledge on the last byte
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b0;
        q();
    endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the serial slave port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tsp_pkg::*;
    localparam int RELOAD_SIM = 1000;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic s0 = 1'b0;
    logic s1 = 1'b0;
    logic scl, m_oe, s_oe, s_do, sda, wr, rd, rld, busy;
    logic [7:0] ra, wd, rdata;
    int errors = 0;
    int samples_checked = 0;
    int reloads = 0;
    int rds = 0;
    int cycles = 0;
    logic [15:0] wlog[$];
    assign sda = !m_oe && !(s_oe && !s_do); // pull-up when nobody pulls low
    assign rdata = ra ^ 8'hA5;
    tsp_i2c_slave #(.RELOAD_CYCLES(RELOAD_SIM)) dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce),
        .LINK_CLK_I(lclk), .SCL_I(scl), .SDA_I(sda), .SDA_O(s_do), .SDA_OE_O(s_oe),
        .ADDR_SELECT_LSB_PIN_I(s0), .ADDR_SELECT_MSB_PIN_I(s1), .REG_ADDR_O(ra), .REG_WDATA_O(wd),
        .REG_WR_O(wr), .REG_RD_O(rd), .REG_RDATA_I(rdata), .DEFAULTS_RELOAD_O(rld), .RELOAD_BUSY_O(busy));
    tsp_bus_master mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #7;
        forever #6 lclk = ~lclk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (wr === 1'b1) wlog.push_back({ra, wd});
        if (rld === 1'b1) reloads++;
        if (rd === 1'b1) rds++;
        if (cycles == 60000) begin
            errors++;
            complete_run();
        end
    end
    task automatic adr(input logic [6:0] a, input logic rw, output logic ack);
        mst.start();
        mst.wbyte({a, rw}, ack);
    endtask
    task automatic test_addr();
        logic ack;
        for (int s = 0; s < 4; s++) begin
            {s1, s0} <= 2'(s);
            adr(7'h48 + 7'(s), 1'b0, ack);
            mst.stop();
            chk("own ack", 16'h1, 16'(ack));
            adr(7'h48 + 7'(s ^ 1), 1'b0, ack);
            mst.stop();
            chk("foreign ack", 16'h0, 16'(ack));
        end
        {s1, s0} <= 2'b01;
        $display("addr done");
    endtask
    task automatic test_write();
        logic ack;
        logic [7:0] b[4] = '{8'h04, 8'h12, 8'h34, 8'h56};
        wlog.delete();
        adr(7'h49, 1'b0, ack);
        for (int i = 0; i < 4; i++) begin
            mst.wbyte(b[i], ack);
            chk("wr ack", 16'h1, 16'(ack));
        end
        mst.stop();
        repeat (10) @(posedge clk);
        chk("wr count", 16'h2, 16'(wlog.size()));
        chk("msb wr", 16'h0412, wlog[0]);
        chk("lsb wr", 16'h0534, wlog[1]);
        $display("write done");
    endtask
    task automatic test_read();
        logic ack;
        logic [7:0] d0, d1;
        int r0;
        for (int k = 0; k < 2; k++) begin
            r0 = rds;
            adr(7'h49, 1'b1, ack); // pointer from the last write
            chk("rd ack", 16'h1, 16'(ack));
            mst.rbyte(1'b0, d0);
            mst.rbyte(1'b1, d1);
            mst.stop();
            chk("rd first", k ? 16'hA6 : 16'hA1, 16'(d0));
            chk("rd second", k ? 16'hA6 : 16'hA0, 16'(d1));
            chk("rd strobes", k ? 16'h1 : 16'h2, 16'(rds - r0));
            adr(7'h49, 1'b0, ack);
            mst.wbyte(8'h03, ack); // one-byte pointer load
            mst.stop();
        end
        $display("read done");
    endtask
    task automatic test_reset(input logic gc);
        logic ack;
        logic [7:0] d0, d1;
        int n = reloads;
        if (gc) begin
            mst.start();
            mst.wbyte(GCALL_BYTE, ack);
            chk("gc ack", 16'h1, 16'(ack));
        end else begin
            adr(7'h49, 1'b0, ack);
        end
        mst.wbyte(gc ? GCALL_RESET : PTR_RESET_CMD, ack);
        mst.stop();
        repeat (10) @(posedge clk);
        chk("reload", 16'(n + 1), 16'(reloads));
        chk("busy on", 16'h1, 16'(busy));
        adr(7'h49, 1'b0, ack);
        mst.stop();
        chk("busy ack", 16'h0, 16'(ack));
        repeat (RELOAD_SIM) @(posedge clk); // wait out the reload
        chk("busy off", 16'h0, 16'(busy));
        mst.start();
        mst.wbyte(GCALL_BYTE, ack);
        mst.wbyte(8'h07, ack);
        mst.stop();
        chk("gc other", 16'h0, 16'(ack));
        adr(7'h49, 1'b1, ack);
        mst.rbyte(1'b0, d0);
        mst.rbyte(1'b1, d1);
        mst.stop();
        chk("ptr default", 16'hA5, 16'(d0));
        chk("ptr default lsb", 16'hA4, 16'(d1));
        $display("reset done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        test_addr();
        test_write();
        test_read();
        test_reset(1'b0);
        test_reset(1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
